// File: shared/dngp_pkg.sv
// Purpose : constants shared by the dual nibble gpio ports
// Assumes : 8-bit data, 12-bit register address
// Notes   : offsets are the register addresses on the plain port
package dngp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PINS   = 4;

    typedef logic [ADDR_W-1:0] dngp_addr_t;
    typedef logic [DATA_W-1:0] dngp_data_t;
    typedef logic [PINS-1:0]   dngp_nib_t;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam dngp_addr_t OSC_PORT_OUTPUT_LATCH_OFS    = 12'h000;
    localparam dngp_addr_t IRQ_PORT_OUTPUT_LATCH_OFS    = 12'h001;
    localparam dngp_addr_t OSC_PORT_PIN_READ_OFS        = 12'h00d;
    localparam dngp_addr_t OSC_PORT_DIRECTION_OFS       = 12'h f1a;
    localparam dngp_addr_t IRQ_PORT_DIRECTION_OFS       = 12'hf1b;
    localparam dngp_addr_t OSC_PORT_PULLUP_ENABLE_OFS   = 12'hf27;
    localparam dngp_addr_t OSC_PORT_FUNCTION_SELECT_OFS = 12'hf34;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam dngp_nib_t  LATCH_RST     = 4'h0;
    localparam dngp_nib_t  DIR_RST       = 4'h0;
    localparam dngp_nib_t  PULLUP_RST    = 4'h0;
    localparam logic       FUNC_SEL_RST  = 1'h0;
    localparam dngp_data_t READ_IDLE     = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned HF_INPUT_FUNCTION_SELECT_BIT = 0;
    localparam int unsigned LF_INPUT_FUNCTION_SELECT_BIT = 2;
    localparam int unsigned HF_IN_PIN   = 0;
    localparam int unsigned HF_OUT_PIN  = 1;
    localparam int unsigned LF_IN_PIN   = 2;
    localparam int unsigned LF_OUT_PIN  = 3;
    localparam int unsigned RESET_PIN   = 0;
    localparam int unsigned EXT_INTERRUPT_FIVE_PIN    = 1;
    localparam int unsigned EXT_INTERRUPT_ZERO_PIN    = 2;
    localparam int unsigned EXT_INTERRUPT_ONE_PIN    = 3;

endpackage

// File: hdl/dngp_pin_cell.sv
// Purpose : registered drive, enable and pull-up for one 4-bit port
// Assumes : enable and pull terms already qualified by the caller
// Notes   : oe_b low means the pin is driven
`timescale 1ns/100ps
module dngp_pin_cell (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire dngp_pkg::dngp_nib_t drive_en_i,
    input  wire dngp_pkg::dngp_nib_t data_i,
    input  wire dngp_pkg::dngp_nib_t pull_i,
    output dngp_pkg::dngp_nib_t      pad_o,
    output dngp_pkg::dngp_nib_t      pad_oe_b_o,
    output dngp_pkg::dngp_nib_t      pullup_o
);
    import dngp_pkg::*;

    typedef struct packed {
        dngp_nib_t pad;
        dngp_nib_t oe_b;
        dngp_nib_t pull;
    } dngp_cell_s;

    dngp_cell_s st_q;
    dngp_cell_s st_d;

    // ------------------------------------------------------------
    // per-pin drive
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < PINS; i++) begin
            st_d.pad[i]  = drive_en_i[i] & data_i[i];
            st_d.oe_b[i] = ~drive_en_i[i];
            st_d.pull[i] = pull_i[i];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q.pad  <= 4'h0;
            st_q.oe_b <= 4'hf;
            st_q.pull <= 4'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pad_o      = st_q.pad;
    assign pad_oe_b_o = st_q.oe_b;
    assign pullup_o   = st_q.pull;

endmodule

// File: hdl/dngp_top.sv
// Purpose : oscillator port and interrupt port, registers and pin logic
// Assumes : pins are synchronous to clk_i; software on the plain register port
// Notes   : read data stand one cycle after the read strobe
// How it works
// - oscillator port has four pins, each with its own direction bit
// - oscillator pins 0/1 serve high-frequency clock, pins 2/3 low-frequency clock
// - latch bit drives pin low or high only while pin is output
// - direction 0 is input, 1 is output from latch; reset to 0
// - select bit 0 takes pin 0, bit 2 takes pin 2 as clock input
// - oscillator enable written 1 with high-frequency select 0 raises clock reset
// - pin read bits 0/1 show pin only if select 0 and input
// - pin read bits 2/3 show pin only if select bit 2 is 0 and input
// - interrupt port has four directed pins with interrupt, release and reset uses
// - after any reset interrupt port pin 0 is the external reset input
// - input pins 3,2,1 feed interrupt one, zero, five and stop release
// - interrupt port latch has four writable bits reset 0, driving output pins
`timescale 1ns/100ps
module dngp_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire dngp_pkg::dngp_addr_t reg_addr_i,
    input  wire dngp_pkg::dngp_data_t reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output dngp_pkg::dngp_data_t      reg_rdata_o,
    input  wire logic                 external_osc_enable_wr_i,
    input  wire logic                 external_osc_enable_wdata_i,
    output logic                      sys_clk_reset_o,
    input  wire logic                 reset_pin_release_i,
    input  wire dngp_pkg::dngp_nib_t  oscillator_port_pin_i,
    output dngp_pkg::dngp_nib_t       oscillator_port_pin_o,
    output dngp_pkg::dngp_nib_t       oscillator_port_pin_oe_b_o,
    output dngp_pkg::dngp_nib_t       oscillator_port_pullup_o,
    output logic                      hf_clock_input_pin_o,
    output logic                      lf_clock_input_pin_o,
    output logic                      hf_osc_pins_claimed_o,
    output logic                      lf_osc_pins_claimed_o,
    input  wire dngp_pkg::dngp_nib_t  interrupt_port_pin_i,
    output dngp_pkg::dngp_nib_t       interrupt_port_pin_o,
    output dngp_pkg::dngp_nib_t       interrupt_port_pin_oe_b_o,
    output logic                      ext_reset_b_o,
    output logic                      ext_interrupt_zero_o,
    output logic                      ext_interrupt_one_o,
    output logic                      ext_interrupt_five_o,
    output logic                      stop_release_o
);
    import dngp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dngp_nib_t  osc_latch;
        dngp_nib_t  irq_latch;
        dngp_nib_t  osc_dir;
        dngp_nib_t  irq_dir;
        dngp_nib_t  osc_pullup;
        logic       hf_sel;
        logic       lf_sel;
        logic       reset_func;
        dngp_data_t rdata;
        logic       clk_reset;
        logic       hf_clk;
        logic       lf_clk;
        logic       hf_claim;
        logic       lf_claim;
        logic       ext_rst_b;
        logic       ext_interrupt_zero;
        logic       ext_interrupt_one;
        logic       ext_interrupt_five;
        logic       stop_rel;
    } dngp_state_s;

    dngp_state_s st_q;
    dngp_state_s st_d;

    dngp_nib_t osc_func_mask;
    dngp_nib_t osc_drive_en;
    dngp_nib_t osc_pull;
    dngp_nib_t irq_drive_en;
    dngp_nib_t osc_read_ok;
    dngp_nib_t pin_read_val;
    dngp_data_t fsel_val;

    // ------------------------------------------------------------
    // pin qualification
    // ------------------------------------------------------------
    always_comb begin
        osc_func_mask = 4'h0;
        osc_func_mask[HF_IN_PIN]  = st_q.hf_sel;
        osc_func_mask[HF_OUT_PIN] = st_q.hf_sel;
        osc_func_mask[LF_IN_PIN]  = st_q.lf_sel;
        osc_func_mask[LF_OUT_PIN] = st_q.lf_sel;
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            assign osc_drive_en[g] = st_q.osc_dir[g] & ~osc_func_mask[g];
            assign osc_pull[g]     = st_q.osc_pullup[g] & ~st_q.osc_dir[g]
                                   & ~osc_func_mask[g];
            assign osc_read_ok[g]  = ~st_q.osc_dir[g] & ~osc_func_mask[g];
            assign pin_read_val[g] = osc_read_ok[g] & oscillator_port_pin_i[g];
            if (g == RESET_PIN) begin : g_rst
                assign irq_drive_en[g] = st_q.irq_dir[g] & ~st_q.reset_func;
            end else begin : g_gp
                assign irq_drive_en[g] = st_q.irq_dir[g];
            end
        end
    endgenerate

    always_comb begin
        fsel_val = 8'h00;
        fsel_val[HF_INPUT_FUNCTION_SELECT_BIT] = st_q.hf_sel;
        fsel_val[LF_INPUT_FUNCTION_SELECT_BIT] = st_q.lf_sel;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // register writes, upper bits dropped
        if (reg_wr_i) begin
            if (reg_addr_i == OSC_PORT_OUTPUT_LATCH_OFS) begin
                st_d.osc_latch = reg_wdata_i[PINS-1:0];
            end else if (reg_addr_i == IRQ_PORT_OUTPUT_LATCH_OFS) begin
                st_d.irq_latch = reg_wdata_i[PINS-1:0];
            end else if (reg_addr_i == OSC_PORT_DIRECTION_OFS) begin
                st_d.osc_dir = reg_wdata_i[PINS-1:0];
            end else if (reg_addr_i == IRQ_PORT_DIRECTION_OFS) begin
                st_d.irq_dir = reg_wdata_i[PINS-1:0];
            end else if (reg_addr_i == OSC_PORT_PULLUP_ENABLE_OFS) begin
                st_d.osc_pullup = reg_wdata_i[PINS-1:0];
            end else if (reg_addr_i == OSC_PORT_FUNCTION_SELECT_OFS) begin
                st_d.hf_sel = reg_wdata_i[HF_INPUT_FUNCTION_SELECT_BIT];
                st_d.lf_sel = reg_wdata_i[LF_INPUT_FUNCTION_SELECT_BIT];
            end
        end

        // register reads, answer in the next cycle only
        st_d.rdata = READ_IDLE;
        if (reg_rd_i) begin
            if (reg_addr_i == OSC_PORT_OUTPUT_LATCH_OFS) begin
                st_d.rdata = {4'h0, st_q.osc_latch};
            end else if (reg_addr_i == IRQ_PORT_OUTPUT_LATCH_OFS) begin
                st_d.rdata = {4'h0, st_q.irq_latch};
            end else if (reg_addr_i == OSC_PORT_PIN_READ_OFS) begin
                st_d.rdata = {4'h0, pin_read_val};
            end else if (reg_addr_i == OSC_PORT_DIRECTION_OFS) begin
                st_d.rdata = {4'h0, st_q.osc_dir};
            end else if (reg_addr_i == IRQ_PORT_DIRECTION_OFS) begin
                st_d.rdata = {4'h0, st_q.irq_dir};
            end else if (reg_addr_i == OSC_PORT_PULLUP_ENABLE_OFS) begin
                st_d.rdata = {4'h0, st_q.osc_pullup};
            end else if (reg_addr_i == OSC_PORT_FUNCTION_SELECT_OFS) begin
                st_d.rdata = fsel_val;
            end
        end

        // bad oscillator enable order; software is expected to avoid it
        st_d.clk_reset = external_osc_enable_wr_i & external_osc_enable_wdata_i
                       & ~st_q.hf_sel;

        // reset pin hand-over to port use
        if (reset_pin_release_i) begin
            st_d.reset_func = 1'b0;
        end

        // oscillator inputs and pin claim
        st_d.hf_clk   = st_q.hf_sel & oscillator_port_pin_i[HF_IN_PIN];
        st_d.lf_clk   = st_q.lf_sel & oscillator_port_pin_i[LF_IN_PIN];
        st_d.hf_claim = st_q.hf_sel;
        st_d.lf_claim = st_q.lf_sel;

        // interrupt port secondary inputs
        st_d.ext_rst_b = ~st_q.reset_func | interrupt_port_pin_i[RESET_PIN];
        st_d.ext_interrupt_one      = ~st_q.irq_dir[EXT_INTERRUPT_ONE_PIN] & interrupt_port_pin_i[EXT_INTERRUPT_ONE_PIN];
        st_d.ext_interrupt_zero      = ~st_q.irq_dir[EXT_INTERRUPT_ZERO_PIN] & interrupt_port_pin_i[EXT_INTERRUPT_ZERO_PIN];
        st_d.ext_interrupt_five      = ~st_q.irq_dir[EXT_INTERRUPT_FIVE_PIN] & interrupt_port_pin_i[EXT_INTERRUPT_FIVE_PIN];
        st_d.stop_rel  = ~st_q.irq_dir[EXT_INTERRUPT_FIVE_PIN] & interrupt_port_pin_i[EXT_INTERRUPT_FIVE_PIN];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q.osc_latch  <= LATCH_RST;
            st_q.irq_latch  <= LATCH_RST;
            st_q.osc_dir    <= DIR_RST;
            st_q.irq_dir    <= DIR_RST;
            st_q.osc_pullup <= PULLUP_RST;
            st_q.hf_sel     <= FUNC_SEL_RST;
            st_q.lf_sel     <= FUNC_SEL_RST;
            st_q.reset_func <= 1'b1;
            st_q.rdata      <= READ_IDLE;
            st_q.clk_reset  <= 1'b0;
            st_q.hf_clk     <= 1'b0;
            st_q.lf_clk     <= 1'b0;
            st_q.hf_claim   <= 1'b0;
            st_q.lf_claim   <= 1'b0;
            st_q.ext_rst_b  <= 1'b1;
            st_q.ext_interrupt_zero       <= 1'b0;
            st_q.ext_interrupt_one       <= 1'b0;
            st_q.ext_interrupt_five       <= 1'b0;
            st_q.stop_rel   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    dngp_pin_cell u_osc_cell (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .drive_en_i (osc_drive_en),
        .data_i     (st_q.osc_latch),
        .pull_i     (osc_pull),
        .pad_o      (oscillator_port_pin_o),
        .pad_oe_b_o (oscillator_port_pin_oe_b_o),
        .pullup_o   (oscillator_port_pullup_o)
    );

    dngp_pin_cell u_irq_cell (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .drive_en_i (irq_drive_en),
        .data_i     (st_q.irq_latch),
        .pull_i     (4'h0),
        .pad_o      (interrupt_port_pin_o),
        .pad_oe_b_o (interrupt_port_pin_oe_b_o),
        .pullup_o   ()
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o           = st_q.rdata;
    assign sys_clk_reset_o       = st_q.clk_reset;
    assign hf_clock_input_pin_o  = st_q.hf_clk;
    assign lf_clock_input_pin_o  = st_q.lf_clk;
    assign hf_osc_pins_claimed_o = st_q.hf_claim;
    assign lf_osc_pins_claimed_o = st_q.lf_claim;
    assign ext_reset_b_o         = st_q.ext_rst_b;
    assign ext_interrupt_zero_o  = st_q.ext_interrupt_zero;
    assign ext_interrupt_one_o   = st_q.ext_interrupt_one;
    assign ext_interrupt_five_o  = st_q.ext_interrupt_five;
    assign stop_release_o        = st_q.stop_rel;

endmodule

// File: testbench/dngp_properties.sv
// Purpose : port-level checks for the dual nibble gpio ports
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound to dngp_top from the bench top file
`timescale 1ns/100ps
module dngp_properties (
    input wire logic                 clk_i,
    input wire logic                 rst_b_i,
    input wire logic                 reg_rd_i,
    input wire dngp_pkg::dngp_data_t reg_rdata_o,
    input wire logic                 external_osc_enable_wr_i,
    input wire logic                 external_osc_enable_wdata_i,
    input wire logic                 sys_clk_reset_o,
    input wire dngp_pkg::dngp_nib_t  oscillator_port_pin_o,
    input wire dngp_pkg::dngp_nib_t  oscillator_port_pin_oe_b_o,
    input wire dngp_pkg::dngp_nib_t  oscillator_port_pullup_o,
    input wire logic                 hf_osc_pins_claimed_o,
    input wire dngp_pkg::dngp_nib_t  interrupt_port_pin_i,
    input wire logic                 ext_reset_b_o,
    input wire logic                 ext_interrupt_zero_o,
    input wire logic                 ext_interrupt_five_o,
    input wire logic                 stop_release_o
);
    import dngp_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not idle");
    drive_gate_a: assert property ((oscillator_port_pin_o & oscillator_port_pin_oe_b_o) == 4'h0)
        else $error("pin value while not driven");
    pull_input_a: assert property ((oscillator_port_pullup_o & ~oscillator_port_pin_oe_b_o) == 4'h0)
        else $error("pull-up on a driven pin");
    clk_reset_cause_a: assert property (sys_clk_reset_o |-> $past(external_osc_enable_wr_i && external_osc_enable_wdata_i))
        else $error("clock reset without enable write");
    ext_reset_pin_a: assert property (!ext_reset_b_o |-> !$past(interrupt_port_pin_i[0]))
        else $error("external reset without low pin");
    irq_zero_pin_a: assert property (ext_interrupt_zero_o |-> $past(interrupt_port_pin_i[2]))
        else $error("interrupt zero not from pin 2");
    irq_five_stop_a: assert property (ext_interrupt_five_o |-> stop_release_o && $past(interrupt_port_pin_i[1]))
        else $error("interrupt five or stop release wrong");
    hf_claim_a: assert property (hf_osc_pins_claimed_o && $past(hf_osc_pins_claimed_o) |-> oscillator_port_pin_oe_b_o[1:0] == 2'b11)
        else $error("claimed pins still driven");
endmodule

// File: testbench/dngp_board_model.sv
// Purpose : board side of both ports: pin levels, pulls, floating lines
// Assumes : bench commands the board drive of every pin
// Notes   : bits 3:0 oscillator port, bits 7:4 interrupt port
`timescale 1ns/100ps
module dngp_board_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pad_i,
    input  wire logic [7:0] oe_b_i,
    input  wire logic [3:0] pull_i,
    input  wire logic [7:0] drv_en_i,
    input  wire logic [7:0] drv_val_i,
    output logic      [7:0] lvl_o
);
    logic [7:0] last_q = 8'h00;
    // a floating line without pull-up flips every cycle
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl_o[i] = !oe_b_i[i] ? pad_i[i] : drv_en_i[i] ? drv_val_i[i] : ((i < 4) && pull_i[i % 4]) | ~last_q[i];
        end
    end
    always @(posedge clk_i) begin
        last_q <= lvl_o;
    end
endmodule

// File: testbench/tb.sv
// Purpose : self-checking bench for the dual nibble gpio ports
// Assumes : board model closes the pins, register port driven at posedge
// Notes   : expected values come from the port behaviour only
`timescale 1ns/100ps
module tb;
    import dngp_pkg::*;
    localparam dngp_addr_t OFS [8] = '{OSC_PORT_OUTPUT_LATCH_OFS, IRQ_PORT_OUTPUT_LATCH_OFS, OSC_PORT_PIN_READ_OFS,
        OSC_PORT_DIRECTION_OFS, IRQ_PORT_DIRECTION_OFS, OSC_PORT_PULLUP_ENABLE_OFS, OSC_PORT_FUNCTION_SELECT_OFS, 12'h002};
    logic       clk_i, rst_b_i, wr, rd, oe_wr, oe_wd, rel, clk_rst, hf_in, lf_in, hf_cl, lf_cl;
    logic       ext_rst_b, ei_zero, ei_one, ei_five, stop_rel;
    dngp_addr_t addr;
    dngp_data_t wdata, rdata;
    dngp_nib_t  osc_in, osc_out, osc_oe_b, osc_pu, irq_in, irq_out, irq_oe_b;
    logic [7:0] drv_en, drv_val;
    int         err_total = 0;
    int         n_compared = 0;
    dngp_top u_dngp_top (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .external_osc_enable_wr_i(oe_wr),
        .external_osc_enable_wdata_i(oe_wd), .sys_clk_reset_o(clk_rst), .reset_pin_release_i(rel),
        .oscillator_port_pin_i(osc_in), .oscillator_port_pin_o(osc_out), .oscillator_port_pin_oe_b_o(osc_oe_b),
        .oscillator_port_pullup_o(osc_pu), .hf_clock_input_pin_o(hf_in), .lf_clock_input_pin_o(lf_in),
        .hf_osc_pins_claimed_o(hf_cl), .lf_osc_pins_claimed_o(lf_cl), .interrupt_port_pin_i(irq_in),
        .interrupt_port_pin_o(irq_out), .interrupt_port_pin_oe_b_o(irq_oe_b), .ext_reset_b_o(ext_rst_b),
        .ext_interrupt_zero_o(ei_zero), .ext_interrupt_one_o(ei_one), .ext_interrupt_five_o(ei_five),
        .stop_release_o(stop_rel));
    dngp_board_model u_dngp_board_model (
        .clk_i(clk_i), .pad_i({irq_out, osc_out}), .oe_b_i({irq_oe_b, osc_oe_b}), .pull_i(osc_pu),
        .drv_en_i(drv_en), .drv_val_i(drv_val), .lvl_o({irq_in, osc_in}));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input dngp_data_t seen, input dngp_data_t exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wreg(input dngp_addr_t a, input dngp_data_t d);
        @(posedge clk_i);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rchk(input dngp_addr_t a, input dngp_data_t exp);
        @(posedge clk_i);
        {rd, addr} <= {1'b1, a};
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic osc_en(input logic d, input logic exp);
        @(posedge clk_i);
        {oe_wr, oe_wd} <= {1'b1, d};
        @(posedge clk_i);
        oe_wr <= 1'b0;
        #1 chk("clk_rst", {7'h0, clk_rst}, {7'h0, exp});
        @(posedge clk_i);
        #1 chk("clk_rst_end", {7'h0, clk_rst}, 8'h00);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rchk(OFS[i], 8'h00);
        chk("oe_b", {irq_oe_b, osc_oe_b}, 8'hff);
        chk("ext_rst_b", {7'h0, ext_rst_b}, 8'h00);
    endtask
    task automatic t_rw;
        dngp_data_t ex [8] = '{8'h0f, 8'h0f, 8'h00, 8'h0c, 8'h0f, 8'h0f, 8'h05, 8'h00};
        for (int i = 0; i < 8; i++) wreg(OFS[i], (i == 3) ? 8'hfc : 8'hff);
        for (int i = 0; i < 8; i++) rchk(OFS[i], ex[i]);
        chk("osc", {osc_oe_b, osc_out}, 8'hf0);
        chk("irq", {irq_oe_b, irq_out}, 8'h1e);
        chk("claim", {osc_pu, 2'h0, lf_cl, hf_cl}, 8'h03);
        chk("ints", {4'h0, ei_one, ei_zero, ei_five, stop_rel}, 8'h00);
        for (int i = 0; i < 8; i++) wreg(OFS[i], 8'h00);
    endtask
    task automatic t_drive;
        drv_val <= 8'h0d;
        wreg(OSC_PORT_DIRECTION_OFS, 8'h03);
        wreg(OSC_PORT_OUTPUT_LATCH_OFS, 8'h02);
        settle;
        chk("osc", {osc_oe_b, osc_out}, 8'hc2);
        rchk(OSC_PORT_PIN_READ_OFS, 8'h0c);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h04);
        rchk(OSC_PORT_PIN_READ_OFS, 8'h00);
        chk("lf_in", {7'h0, lf_in}, 8'h01);
        wreg(OSC_PORT_DIRECTION_OFS, 8'h00);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h01);
        rchk(OSC_PORT_PIN_READ_OFS, 8'h0c);
        chk("clk_in", {6'h0, lf_in, hf_in}, 8'h01);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h00);
    endtask
    task automatic t_pull;
        drv_en <= 8'hf0;
        wreg(OSC_PORT_DIRECTION_OFS, 8'h01);
        wreg(OSC_PORT_PULLUP_ENABLE_OFS, 8'h0f);
        settle;
        chk("pullup", {4'h0, osc_pu}, 8'h0e);
        rchk(OSC_PORT_PIN_READ_OFS, 8'h0e);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h04);
        settle;
        chk("pullup", {4'h0, osc_pu}, 8'h02);
        drv_en <= 8'hff;
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h00);
        wreg(OSC_PORT_PULLUP_ENABLE_OFS, 8'h00);
        wreg(OSC_PORT_DIRECTION_OFS, 8'h00);
    endtask
    task automatic t_clkrst;
        osc_en(1'b1, 1'b1);
        osc_en(1'b0, 1'b0);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h01);
        osc_en(1'b1, 1'b0);
        wreg(OSC_PORT_FUNCTION_SELECT_OFS, 8'h00);
    endtask
    task automatic t_irq;
        drv_val <= 8'hf0;
        settle;
        chk("ints", {3'h0, ext_rst_b, ei_one, ei_zero, ei_five, stop_rel}, 8'h1f);
        drv_val <= 8'ha0;
        settle;
        chk("ints", {3'h0, ext_rst_b, ei_one, ei_zero, ei_five, stop_rel}, 8'h0b);
        wreg(IRQ_PORT_DIRECTION_OFS, 8'h0f);
        wreg(IRQ_PORT_OUTPUT_LATCH_OFS, 8'h05);
        settle;
        chk("irq", {irq_oe_b, irq_out}, 8'h14);
        chk("ints", {3'h0, ext_rst_b, ei_one, ei_zero, ei_five, stop_rel}, 8'h00);
        rel <= 1'b1;
        @(posedge clk_i);
        rel <= 1'b0;
        settle;
        chk("irq", {irq_oe_b, irq_out}, 8'h05);
        chk("ext_rst_b", {7'h0, ext_rst_b}, 8'h01);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        settle;
        chk("irq", {3'h0, ext_rst_b, irq_oe_b}, 8'h0f);
    endtask
    initial begin
        {rst_b_i, wr, rd, oe_wr, oe_wd, rel} = 6'h00;
        {addr, wdata} = 20'h00000;
        {drv_en, drv_val} = 16'hff00;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_rw;
        t_drive;
        t_pull;
        t_clkrst;
        t_irq;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        give_verdict;
    end
endmodule
bind dngp_top dngp_properties u_dngp_properties (.*);
